// ===== asr_pkg.sv
/*
 * Constants, register map and carrier types for the serial receiver.
 * Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`default_nettype none
package asr_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int OVERSAMPLE = 16;
	localparam int AW = 5;
	localparam logic [AW-1:0] OFF_CTRL_ONE = 5'h00;
	localparam logic [AW-1:0] OFF_CTRL_TWO = 5'h04;
	localparam logic [AW-1:0] OFF_STAT_ONE = 5'h08;
	localparam logic [AW-1:0] OFF_DATA_BUF = 5'h0c;
	localparam logic [AW-1:0] OFF_IRQ_STAT = 5'h10;
	localparam logic [AW-1:0] OFF_IRQ_MASK = 5'h14;
	localparam logic [AW-1:0] OFF_BAUD_DIV = 5'h18;
	// Control field positions
	localparam int CTL1_MOD_EN = 0;
	localparam int CTL1_LEN9 = 1;
	localparam int CTL2_RX_EN = 0;
	localparam int CTL2_RX_IE = 1;
	// Interrupt event bits
	localparam int IRQ_RX_CHAR = 0;
	localparam int IRQ_RX_ERR = 1;
	// Reset values
	localparam logic [1:0] CTRL_ONE_RST = 2'h0;
	localparam logic [1:0] CTRL_TWO_RST = 2'h0;
	localparam logic [1:0] IRQ_MASK_RST = 2'h0;
	localparam logic [15:0] BAUD_DIV_RST = 16'h0014;
	// Oversample positions within one bit period
	localparam logic [4:0] RT_EDGE = 5'h01;
	localparam logic [4:0] RT_S1 = 5'h03;
	localparam logic [4:0] RT_S2 = 5'h05;
	localparam logic [4:0] RT_S3 = 5'h07;
	localparam logic [4:0] RT_D1 = 5'h08;
	localparam logic [4:0] RT_D2 = 5'h09;
	localparam logic [4:0] RT_D3 = 5'h0a;
	localparam logic [4:0] RT_LAST = 5'h10;
	localparam logic [7:0] STOP_RT_8BIT = 8'd154;
	localparam logic [7:0] STOP_RT_9BIT = 8'd170;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		ST_SEARCH = 4'b0001,
		ST_START  = 4'b0010,
		ST_DATA   = 4'b0100,
		ST_STOP   = 4'b1000
	} asr_state_t;

	typedef struct packed {
		logic ninth;
		logic brk;
		logic ovr;
		logic noise;
		logic frame;
		logic full;
	} asr_stat_t;

	localparam asr_stat_t STAT_RST = '0;
endpackage
`default_nettype wire

// ===== asr_rx.sv
/*
 * Oversampling asynchronous serial receiver with AXI4-Lite register slave.
 * Assumes rxd is asynchronous to aclk and idles high; one bus master.
 */
// Summary of operation
// - Eight or nine data bits per control bit
// - Ninth bit, or copy of bit 7
// - Completed character loads buffer, sets full flag
// - Full flag with enable raises interrupt
// - Sample line at sixteen times baud
// - Resync counter on start and falling edges
// - Start after three highs then low
// - Confirm start by RT3/5/7 vote, noise
// - Failed start resets counter, search again
// - Data bit majority vote, noise on disagreement
// - Stop vote low gives framing error, noise
// - Framing error sets with full flag
// - Stop sampled at 154 or 170 ticks
// - Late stop bit still clean
// - Break is all zeros plus low stop
// - Break sets flags, clears buffer, ninth bit
// - Overrun keeps old character, drops new one
`timescale 1ns/1ps
`default_nettype none
module asr_rx
	import asr_pkg::*;
(
	input  wire logic            aclk,
	input  wire logic            aresetn,
	input  wire logic [AW-1:0]   s_awaddr,
	input  wire logic            s_awvalid,
	output logic                 s_awready,
	input  wire logic [31:0]     s_wdata,
	input  wire logic [3:0]      s_wstrb,
	input  wire logic            s_wvalid,
	output logic                 s_wready,
	output logic [1:0]           s_bresp,
	output logic                 s_bvalid,
	input  wire logic            s_bready,
	input  wire logic [AW-1:0]   s_araddr,
	input  wire logic            s_arvalid,
	output logic                 s_arready,
	output logic [31:0]          s_rdata,
	output logic [1:0]           s_rresp,
	output logic                 s_rvalid,
	input  wire logic            s_rready,
	input  wire logic            rxd,
	output logic                 irq
);
	import asr_pkg::*;

	function automatic logic maj3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	function automatic logic differ3(input logic a, input logic b, input logic c);
		return (a != b) || (a != c);
	endfunction

	logic [1:0]      ctrl_one_q;
	logic [1:0]      ctrl_two_q;
	logic [1:0]      irq_stat_q;
	logic [1:0]      irq_mask_q;
	logic [15:0]     baud_q;
	asr_stat_t       st_q;
	logic [7:0]      buf_q;
	logic            arm_q;
	logic [AW-1:0]   aw_addr_q;
	logic            aw_have_q;
	logic [31:0]     w_data_q;
	logic [3:0]      w_strb_q;
	logic            w_have_q;
	logic [15:0]     div_q;
	logic            tick_q;
	logic [1:0]      sync_q;
	asr_state_t      state_q;
	logic [4:0]      rt_q;
	logic [3:0]      bit_q;
	logic [8:0]      shreg_q;
	logic [2:0]      hist_q;
	logic [1:0]      votes_q;
	logic [1:0]      samp_q;
	logic            nf_acc_q;
	logic            prev_bit_q;
	logic            last_s_q;

	logic rx_s, run, len9, done, stop_v, frame_noise, brk, accept, clr, wr_go, ar_hs;
	logic fall, start_ones_hi;
	logic [1:0] start_total;
	logic [8:0] data_word;

	assign rx_s = sync_q[1];
	assign run = ctrl_one_q[CTL1_MOD_EN] & ctrl_two_q[CTL2_RX_EN];
	assign len9 = ctrl_one_q[CTL1_LEN9];
	assign fall = last_s_q & ~rx_s;
	assign start_total = votes_q + {1'b0, rx_s};
	assign start_ones_hi = (start_total >= 2'd2);
	assign done = run & tick_q & (state_q == ST_STOP) & (rt_q == RT_D3);
	assign stop_v = maj3(samp_q[0], samp_q[1], rx_s);
	assign frame_noise = nf_acc_q | differ3(samp_q[0], samp_q[1], rx_s);
	assign data_word = len9 ? shreg_q : {1'b0, shreg_q[7:0]};
	assign brk = (data_word == 9'h000) & ~stop_v;
	assign ar_hs = s_arvalid & s_arready;
	assign clr = ar_hs & (s_araddr == OFF_DATA_BUF) & arm_q;
	assign accept = done & (~st_q.full | clr);
	assign wr_go = aw_have_q & w_have_q & ~s_bvalid;

	// Line synchroniser, two stages before any use
	always_ff @(posedge aclk) begin
		if (!aresetn) sync_q <= 2'b11;
		else sync_q <= {sync_q[0], rxd};
	end

	// Oversample tick at sixteen times the baud rate
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else if (div_q >= baud_q) begin
			div_q <= '0;
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// Bit recovery
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			state_q <= ST_SEARCH;
			rt_q <= RT_EDGE;
			bit_q <= '0;
			shreg_q <= '0;
			hist_q <= '0;
			votes_q <= '0;
			samp_q <= '0;
			nf_acc_q <= 1'b0;
			prev_bit_q <= 1'b0;
			last_s_q <= 1'b1;
		end else if (tick_q) begin
			last_s_q <= rx_s;
			unique case (state_q)
				ST_SEARCH: begin
					hist_q <= {hist_q[1:0], rx_s};
					if (hist_q == 3'b111 && !rx_s) begin
						state_q <= ST_START;
						// Edge tick is RT1, so the next tick is RT2
						rt_q <= RT_EDGE + 5'h01;
						votes_q <= '0;
						nf_acc_q <= 1'b0;
					end
				end
				ST_START: begin
					rt_q <= rt_q + 5'h01;
					if ((rt_q == RT_S1 || rt_q == RT_S2) && rx_s) votes_q <= votes_q + 2'h1;
					if (rt_q == RT_S3) begin
						if (start_ones_hi) begin
							state_q <= ST_SEARCH;
							rt_q <= RT_EDGE;
							hist_q <= '0;
						end else if (start_total == 2'd1) begin
							nf_acc_q <= 1'b1;
						end
					end
					if (rt_q == RT_LAST) begin
						state_q <= ST_DATA;
						rt_q <= RT_EDGE;
						bit_q <= '0;
						prev_bit_q <= 1'b0;
					end
				end
				ST_DATA, ST_STOP: begin
					rt_q <= rt_q + 5'h01;
					if (rt_q == RT_D1) samp_q[0] <= rx_s;
					if (rt_q == RT_D2) samp_q[1] <= rx_s;
					if (state_q == ST_DATA && rt_q == RT_D3) begin
						shreg_q[bit_q] <= maj3(samp_q[0], samp_q[1], rx_s);
						prev_bit_q <= maj3(samp_q[0], samp_q[1], rx_s);
						if (differ3(samp_q[0], samp_q[1], rx_s)) nf_acc_q <= 1'b1;
					end
					// A falling edge after a high bit realigns the count
					if (state_q == ST_DATA && prev_bit_q && fall && rt_q > RT_EDGE
							&& rt_q < RT_D1) begin
						rt_q <= RT_EDGE + 5'h01;
					end else if ((state_q == ST_DATA && prev_bit_q && fall && rt_q > RT_D3)
							|| (state_q == ST_DATA && rt_q == RT_LAST)) begin
						rt_q <= (prev_bit_q && fall) ? RT_EDGE + 5'h01 : RT_EDGE;
						// Previous bit kept so a late edge at RT2..7 still realigns
						bit_q <= bit_q + 4'h1;
						if (bit_q == (len9 ? 4'h8 : 4'h7)) state_q <= ST_STOP;
					end
					// Ends at RT10; a stop bit arriving as late as RT8 is still clean
					if (state_q == ST_STOP && rt_q == RT_D3) begin
						state_q <= ST_SEARCH;
						rt_q <= RT_EDGE;
						hist_q <= '0;
					end
				end
			endcase
		end
	end

	// Receive status and data buffer; set wins over the read clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= STAT_RST;
			buf_q <= '0;
			arm_q <= 1'b0;
		end else begin
			if (ar_hs && s_araddr == OFF_STAT_ONE) arm_q <= st_q.full;
			if (clr) begin
				arm_q <= 1'b0;
				st_q <= '{ninth: st_q.ninth, default: 1'b0};
			end
			if (done && !accept) st_q.ovr <= 1'b1;
			if (accept) begin
				st_q.full <= 1'b1;
				st_q.frame <= ~stop_v;
				st_q.noise <= frame_noise;
				st_q.brk <= brk;
				st_q.ovr <= clr ? 1'b0 : st_q.ovr;
				buf_q <= brk ? 8'h00 : data_word[7:0];
				st_q.ninth <= brk ? 1'b0 : (len9 ? shreg_q[8] : shreg_q[7]);
			end
		end
	end

	// Interrupt events and output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= '0;
			irq <= 1'b0;
		end else begin
			if (wr_go && aw_addr_q == OFF_IRQ_STAT && w_strb_q[0])
				irq_stat_q <= irq_stat_q & ~w_data_q[1:0];
			if (accept) irq_stat_q[IRQ_RX_CHAR] <= 1'b1;
			if ((accept && (frame_noise || !stop_v)) || (done && !accept))
				irq_stat_q[IRQ_RX_ERR] <= 1'b1;
			irq <= (st_q.full & ctrl_two_q[CTL2_RX_IE]) | (|(irq_stat_q & irq_mask_q));
		end
	end

	// AXI4-Lite write side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			s_awready <= 1'b1;
			s_wready <= 1'b1;
			s_bvalid <= 1'b0;
			s_bresp <= RESP_OKAY;
			ctrl_one_q <= CTRL_ONE_RST;
			ctrl_two_q <= CTRL_TWO_RST;
			irq_mask_q <= IRQ_MASK_RST;
			baud_q <= BAUD_DIV_RST;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_addr_q <= s_awaddr;
				aw_have_q <= 1'b1;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_data_q <= s_wdata;
				w_strb_q <= s_wstrb;
				w_have_q <= 1'b1;
				s_wready <= 1'b0;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
				s_awready <= 1'b1;
				s_wready <= 1'b1;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= RESP_OKAY;
				unique case (aw_addr_q)
					OFF_CTRL_ONE: if (w_strb_q[0]) ctrl_one_q <= w_data_q[1:0];
					OFF_CTRL_TWO: if (w_strb_q[0]) ctrl_two_q <= w_data_q[1:0];
					OFF_IRQ_MASK: if (w_strb_q[0]) irq_mask_q <= w_data_q[1:0];
					OFF_BAUD_DIV: begin
						if (w_strb_q[0]) baud_q[7:0] <= w_data_q[7:0];
						if (w_strb_q[1]) baud_q[15:8] <= w_data_q[15:8];
					end
					OFF_STAT_ONE, OFF_DATA_BUF, OFF_IRQ_STAT: ;
					default: s_bresp <= RESP_SLVERR;
				endcase
			end
		end
	end

	// AXI4-Lite read side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b1;
			s_rvalid <= 1'b0;
			s_rdata <= '0;
			s_rresp <= RESP_OKAY;
		end else if (ar_hs) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b1;
			s_rresp <= RESP_OKAY;
			unique case (s_araddr)
				OFF_CTRL_ONE: s_rdata <= {30'h0, ctrl_one_q};
				OFF_CTRL_TWO: s_rdata <= {30'h0, ctrl_two_q};
				OFF_STAT_ONE: s_rdata <= {26'h0, st_q};
				OFF_DATA_BUF: s_rdata <= {24'h0, buf_q};
				OFF_IRQ_STAT: s_rdata <= {30'h0, irq_stat_q};
				OFF_IRQ_MASK: s_rdata <= {30'h0, irq_mask_q};
				OFF_BAUD_DIV: s_rdata <= {16'h0, baud_q};
				default: begin
					s_rdata <= '0;
					s_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
			s_arready <= 1'b1;
		end
	end

	// Tick count from start edge, only meaningful for frames with no realignment
	logic [7:0] edge_cnt_q;
	logic       resynced_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			edge_cnt_q <= '0;
			resynced_q <= 1'b0;
		end else if (tick_q) begin
			edge_cnt_q <= edge_cnt_q + 8'h01;
			if (state_q == ST_SEARCH) begin
				edge_cnt_q <= 8'h01;
				resynced_q <= 1'b0;
			end
			if (state_q == ST_DATA && prev_bit_q && fall && rt_q != RT_EDGE
					&& (rt_q < RT_D1 || rt_q > RT_D3)) resynced_q <= 1'b1;
		end
	end

	a_stop_timing: assert property (@(posedge aclk) disable iff (!aresetn)
		(done && !resynced_q) |-> ((edge_cnt_q + 8'h01) == (len9 ? STOP_RT_9BIT : STOP_RT_8BIT)))
		else $error("stop bit sampled at wrong tick");
	a_buf_load: assert property (@(posedge aclk) disable iff (!aresetn)
		(accept && !brk) |=> (st_q.full && buf_q == $past(data_word[7:0])))
		else $error("buffer not loaded on completion");
	a_ninth_copy: assert property (@(posedge aclk) disable iff (!aresetn)
		(accept && !brk && !len9) |=> (st_q.ninth == $past(shreg_q[7])))
		else $error("ninth bit not copy of bit 7");
	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_q.full && ctrl_two_q[CTL2_RX_IE]) |=> irq)
		else $error("receive interrupt missing");
	a_start_fail: assert property (@(posedge aclk) disable iff (!aresetn)
		(run && tick_q && state_q == ST_START && rt_q == RT_S3 && start_ones_hi)
		|=> (state_q == ST_SEARCH && rt_q == RT_EDGE))
		else $error("failed start not abandoned");
	a_start_noise: assert property (@(posedge aclk) disable iff (!aresetn)
		(run && tick_q && state_q == ST_START && rt_q == RT_S3 && start_total == 2'd1)
		|=> (nf_acc_q && state_q == ST_START))
		else $error("start noise not recorded");
	a_overrun_keep: assert property (@(posedge aclk) disable iff (!aresetn)
		(done && !accept) |=> (st_q.ovr && $stable(buf_q)))
		else $error("overrun handling wrong");
	a_break_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		(accept && brk) |=> (st_q.brk && st_q.frame && buf_q == 8'h00 && !st_q.ninth))
		else $error("break flags wrong");
	a_frame_full: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(st_q.frame) |-> $rose(st_q.full) || $past(st_q.full && clr))
		else $error("framing error without full flag");
	a_disabled_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		(!run) |=> (state_q == ST_SEARCH && $stable(st_q.full)))
		else $error("receiver active while disabled");
endmodule // asr_rx
`default_nettype wire

// ===== asr_tx_model.sv
/*
 * Remote serial transmitter model driving the receive line.
 * Assumes one system clock; the line idles high between frames.
 */
`timescale 1ns/1ps
`default_nettype none
module asr_tx_model (
	input  wire logic aclk,
	output logic      rxd
);
	initial rxd = 1'b1;

	// Idle bit, start, LSB first, stop at chosen level; optional 2-clock glitch
	task automatic send(input logic [8:0] d, input int nb, input logic stp,
		input int bc, input int gb, input int go);
		logic v;
		repeat (bc) @(posedge aclk);
		for (int i = 0; i < nb + 2; i++) begin
			v = i == 0 ? 1'b0 : (i > nb ? stp : d[i - 1]);
			for (int c = 0; c < bc; c++) begin
				@(posedge aclk);
				rxd <= (i == gb && (c == go || c == go + 1)) ? ~v : v;
			end
		end
		@(posedge aclk);
		rxd <= 1'b1;
	endtask

	// Short low spike, too brief to pass start confirmation
	task automatic low_pulse(input int n);
		@(posedge aclk);
		rxd <= 1'b0;
		repeat (n) @(posedge aclk);
		rxd <= 1'b1;
	endtask
endmodule // asr_tx_model
`default_nettype wire

// ===== async_serial_receiver_recovery_test.sv
/*
 * Self-checking bench for the serial receiver.
 * Assumes the transmitter model owns rxd and bus tasks own AXI4-Lite.
 */
`timescale 1ns/1ps
`default_nettype none
module async_serial_receiver_recovery_test;
	import asr_pkg::*;
	logic          aclk = 1'b0;
	logic          aresetn = 1'b0;
	logic [AW-1:0] s_awaddr = '0;
	logic [AW-1:0] s_araddr = '0;
	logic          s_awvalid = 1'b0;
	logic          s_wvalid = 1'b0;
	logic          s_bready = 1'b0;
	logic          s_arvalid = 1'b0;
	logic          s_rready = 1'b0;
	logic [31:0]   s_wdata = '0;
	logic [3:0]    s_wstrb = 4'hf;
	logic          s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0]    s_bresp, s_rresp;
	logic [31:0]   s_rdata;
	logic          irq, rxd;
	int            num_errors = 0;
	int            n_checks = 0;
	logic [31:0]   rv;
	logic [1:0]    rr;
	logic [7:0]    sd = 8'h32;
	logic          nin = 1'b0;
	logic          sticky = 1'b0;
	int            exp_q[$];

	always #12.5 aclk = ~aclk;

	asr_rx u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.rxd(rxd), .irq(irq)
	);

	asr_tx_model u_tx (
		.aclk(aclk),
		.rxd(rxd)
	);

	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("Errors %0d, checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_awaddr <= a;
		s_awvalid <= 1'b1;
		s_wdata <= d;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (!s_bvalid);
		s_bready <= 1'b0;
		chk(s_bresp, er);
	endtask

	task automatic rd(input logic [AW-1:0] a);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 1'b0;
		end while (!s_rvalid);
		rv = s_rdata;
		rr = s_rresp;
		s_rready <= 1'b0;
	endtask

	// Send one character, then drain it with the status-then-data sequence
	task automatic rx(input logic [8:0] d, input int nb, input logic stp, input int bc,
		input int gb, input int go, input logic [4:0] f);
		nin = f[4] ? 1'b0 : (nb == 9 ? d[8] : d[7]);
		exp_q.push_back(f[4] ? 0 : int'(d[7:0]));
		u_tx.send(d, nb, stp, bc, gb, go);
		chk(irq, 1'b1);
		rd(OFF_STAT_ONE);
		chk(rv, {26'h0, nin, f});
		rd(OFF_DATA_BUF);
		chk(rv, exp_q.pop_front());
		rd(OFF_STAT_ONE);
		chk(rv, {26'h0, nin, 5'h0});
		chk(irq, sticky);
	endtask

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		// Every register at reset, plus one unmapped word
		for (int i = 0; i < 8; i++) begin
			rd(AW'(i * 4));
			chk(rv, i == 6 ? 32'h14 : 32'h0);
			chk(rr, i == 7 ? RESP_SLVERR : RESP_OKAY);
		end
		wr(5'h1c, 32'h1, RESP_SLVERR);
		wr(OFF_BAUD_DIV, 32'h1, RESP_OKAY);
		wr(OFF_CTRL_TWO, 32'h3, RESP_OKAY);
		for (int j = 0; j < 6; j++) begin
			wr(OFF_CTRL_ONE, j[0] ? 32'h3 : 32'h1, RESP_OKAY);
			sd = nxt(sd);
			rx({sd[0] ^ sd[3], sd}, j[0] ? 9 : 8, 1'b1, 32, -1, 0, 5'h01);
		end
		rx(9'h000, 9, 1'b0, 32, -1, 0, 5'h13);
		wr(OFF_CTRL_ONE, 32'h1, RESP_OKAY);
		rx(9'h0ff, 8, 1'b1, 33, -1, 0, 5'h01);
		// Drift large enough that only realignment keeps the frame clean
		rx(9'h055, 8, 1'b1, 30, -1, 0, 5'h01);
		rx(9'h055, 8, 1'b1, 34, -1, 0, 5'h01);
		rx(9'h0c3, 8, 1'b1, 32, 0, 8, 5'h05);
		rx(9'h096, 8, 1'b1, 32, 4, 18, 5'h05);
		rx(9'h0e7, 8, 1'b1, 32, 9, 18, 5'h05);
		rx(9'h055, 8, 1'b0, 32, -1, 0, 5'h03);
		rx(9'h000, 8, 1'b0, 32, -1, 0, 5'h13);
		// Spike fails confirmation; the next frame must still land cleanly
		u_tx.low_pulse(4);
		rx(9'h03a, 8, 1'b1, 32, -1, 0, 5'h01);
		u_tx.send(9'h0a5, 8, 1'b1, 32, -1, 0);
		u_tx.send(9'h0bc, 8, 1'b1, 32, -1, 0);
		rd(OFF_STAT_ONE);
		chk(rv, 32'h29);
		rd(OFF_DATA_BUF);
		chk(rv, 32'ha5);
		nin = 1'b1;
		// Sticky event through the mask, with the full-flag enable off
		wr(OFF_IRQ_STAT, 32'h3, RESP_OKAY);
		rd(OFF_IRQ_STAT);
		chk(rv, 32'h0);
		wr(OFF_CTRL_TWO, 32'h1, RESP_OKAY);
		wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
		sticky = 1'b1;
		rx(9'h05a, 8, 1'b1, 32, -1, 0, 5'h01);
		rd(OFF_IRQ_STAT);
		chk(rv, 32'h1);
		wr(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
		rd(OFF_IRQ_STAT);
		chk(rv, 32'h0);
		chk(irq, 1'b0);
		// Receiver off: a full frame must leave no trace
		wr(OFF_CTRL_TWO, 32'h0, RESP_OKAY);
		u_tx.send(9'h0f0, 8, 1'b1, 32, -1, 0);
		rd(OFF_STAT_ONE);
		chk(rv, {26'h0, nin, 5'h0});
		conclude();
	end

	// About five times the expected run length
	initial begin
		repeat (40000) @(posedge aclk);
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		conclude();
	end
endmodule // async_serial_receiver_recovery_test
`default_nettype wire
